// ### rtl/nfh_pkg.sv
// Purpose: Constants for the host-side controller of a parallel NOR flash bus.
// Assumes: 10 MHz ref_clk, word-wide or byte-wide flash, asynchronous device bus.
// Notes:   Timing counts are derived from times in nanoseconds.
package nfh_pkg;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          ADDR_W          = 23;
	localparam int          DATA_W          = 16;
	// ----------------------------------------
	// Bus timing (least times round up)
	// ----------------------------------------
	localparam int          ACCESS_NS       = 70;
	localparam int          ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int          WR_PULSE_NS     = 45;
	localparam int          WR_PULSE_CYC    = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RST_PULSE_NS    = 500;
	localparam int          RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W           = 4;
	// ----------------------------------------
	// Status word bit positions
	// ----------------------------------------
	localparam int          POLLING_BIT     = 7;
	localparam int          TOGGLE_BIT      = 6;
	localparam int          FAILURE_BIT     = 5;
	localparam int          ERASE_WIN_BIT   = 3;
	localparam int          ALT_TOGGLE_BIT  = 2;
	localparam int          BUF_ABORT_BIT   = 1;
	localparam int          STATUS_W        = 8;
	// ----------------------------------------
	// Command codes sent by the host
	// ----------------------------------------
	localparam logic [15:0] CMD_READ_RESET  = 16'h00F0;
	localparam logic [15:0] CMD_ABORT_RESET = 16'h00F0;
	localparam logic [15:0] DATA_ZERO       = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;

	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_POLL,
		OP_HWRESET
	} nfh_op_t;

	typedef enum {
		ST_IDLE,
		ST_RD_WAIT,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_POLL_A,
		ST_POLL_B,
		ST_RST_LOW,
		ST_GAP
	} nfh_state_t;
endpackage

// ### rtl/nfh_host.sv
// Purpose: Host controller that drives the flash bus pins and polls status.
// Assumes: One op at a time; device pins are asynchronous to ref_clk.
// Notes:   Data bus uses three signals per pin; dq_oe_n low while driving.
// Notes on behaviour
// [R1] Blocks are uniform 64K words from zero
// [R2] Read: select and output enable low
// [R3] Device latches address on last falling strobe
// [R4] Device latches data on first rising strobe
// [R5] Output enable stays high through writes
// [R6] Select high puts device in standby
// [R7] Output enable high floats device data
// [R8] Reset low deselects and floats device
// [R9] Glitches under 5ns on strobes ignored
// [R10] Eight-word page selected by low address
// [R11] Extended blocks and CFI read singly
// [R12] Polling flag inverts programmed bit while busy
// [R13] Polling flag zero during erase, one done
// [R14] Toggle flag inverts each read while busy
// [R15] Toggle stops once erase actually suspended
// [R16] Failure flag one on failed operation
// [R17] Host issues read/reset after failure
// [R18] Erase-window flag one once erase runs
// [R19] Alt toggle inverts within erasing blocks
// [R20] Buffer abort needs abort-and-reset command
// [R21] Busy reads return status on low byte
// [R22] Device returns to read mode after success
// [R23] Suspended reads outside erase give data
// [R24] Width select low means byte mode
module nfh_host
	import nfh_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic              cmd_valid,
	input  wire nfh_op_t           cmd_op,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_data,
	input  wire logic              cmd_word_mode,
	output logic                   cmd_ready,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	output logic                   rsp_done,
	output logic                   rsp_failure,
	output logic                   rsp_abort,
	output logic                   rsp_erase_window,
	output logic                   rsp_alt_toggled,
	output logic                   recover_busy,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic                   flash_rst_n,
	output logic                   flash_byte_n,
	output logic [DATA_W-1:0]      flash_dq_o,
	output logic                   flash_dq_oe_n,
	input  wire logic [DATA_W-1:0] flash_dq_i
);
	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		nfh_state_t          st;
		logic [CNT_W-1:0]    cnt;
		logic [DATA_W-1:0]   dq_s1;
		logic [DATA_W-1:0]   dq_s2;
		logic [STATUS_W-1:0] first_rd;
		logic                recover;
		logic                ready;
		logic                rv;
		logic [DATA_W-1:0]   rdata;
		logic                done;
		logic                fail;
		logic                abort;
		logic                ewin;
		logic                alt;
		logic [ADDR_W-1:0]   addr;
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic                rst_n;
		logic                byte_n;
		logic [DATA_W-1:0]   dq_o;
		logic                dq_oe_n;
	} nfh_host_t;

	nfh_host_t s_reg;
	nfh_host_t s_next;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next       = s_reg;
		s_next.dq_s1 = flash_dq_i;
		s_next.dq_s2 = s_reg.dq_s1;
		s_next.rv    = 1'b0;
		s_next.cnt   = (s_reg.cnt == CNT_ZERO) ? CNT_ZERO : s_reg.cnt - 4'h1;
		unique case (s_reg.st)
			ST_IDLE: begin
				if (s_reg.recover) begin
					// Failure or abort must be cleared before anything else
					s_next.recover = 1'b0; // R17 R20
					s_next.addr    = '0;
					s_next.dq_o    = CMD_READ_RESET;
					s_next.oe_n    = 1'b1; // R5
					s_next.ready   = 1'b0;
					s_next.st      = ST_WR_SETUP;
				end else if (cmd_valid && s_reg.ready) begin
					s_next.ready  = 1'b0;
					s_next.addr   = cmd_addr; // R1 R10 R11
					s_next.byte_n = cmd_word_mode; // R24
					s_next.done   = 1'b0;
					unique case (cmd_op)
						OP_READ, OP_POLL: begin
							s_next.ce_n = 1'b0; // R2
							s_next.oe_n = 1'b0;
							s_next.cnt  = CNT_W'(ACCESS_CYC);
							s_next.st   = (cmd_op == OP_POLL) ? ST_POLL_A : ST_RD_WAIT;
						end
						OP_WRITE: begin
							s_next.dq_o = cmd_data;
							s_next.st   = ST_WR_SETUP;
						end
						OP_HWRESET: begin
							s_next.rst_n = 1'b0; // R8
							s_next.cnt   = CNT_W'(RST_PULSE_CYC);
							s_next.st    = ST_RST_LOW;
						end
					endcase
				end
			end
			ST_RD_WAIT: begin
				if (s_reg.cnt == CNT_ZERO) begin
					s_next.rdata = s_reg.dq_s2;
					s_next.rv    = 1'b1;
					s_next.done  = 1'b1;
					s_next.ce_n  = 1'b1; // R6
					s_next.oe_n  = 1'b1; // R7
					s_next.st    = ST_GAP;
				end
			end
			ST_WR_SETUP: begin
				// Select and strobe fall in the same cycle; the address was set up a cycle before
				s_next.ce_n    = 1'b0;
				s_next.dq_oe_n = 1'b0;
				s_next.we_n    = 1'b0; // R3
				s_next.cnt     = CNT_W'(WR_PULSE_CYC);
				s_next.st      = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				if (s_reg.cnt == CNT_ZERO) begin
					s_next.we_n = 1'b1; // R4
					s_next.st   = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				s_next.ce_n    = 1'b1;
				s_next.dq_oe_n = 1'b1;
				s_next.st      = ST_GAP;
			end
			ST_POLL_A: begin
				// Two reads: a toggling bit means the operation still runs
				if (s_reg.cnt == CNT_ZERO) begin
					s_next.first_rd = s_reg.dq_s2[STATUS_W-1:0]; // R21
					s_next.oe_n     = 1'b1;
					s_next.cnt      = CNT_W'(ACCESS_CYC);
					s_next.st       = ST_POLL_B;
				end else if (s_reg.cnt == CNT_W'(1)) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end
			end
			ST_POLL_B: begin
				s_next.oe_n = 1'b0;
				if (s_reg.cnt == CNT_ZERO && !s_reg.oe_n) begin
					s_next.rdata = s_reg.dq_s2;
					s_next.rv    = 1'b1;
					// R14 R15 R22 R23: no toggle means finished, suspended or array data
					s_next.done  = (s_reg.first_rd[TOGGLE_BIT] == s_reg.dq_s2[TOGGLE_BIT]);
					// R12 R13: polling flag not read; done comes from the toggle bit alone
					// Both reads must flag it: status giving way to array data is no fault
					s_next.fail  = s_reg.first_rd[FAILURE_BIT] && s_reg.dq_s2[FAILURE_BIT] && !s_next.done; // R16
					s_next.abort = s_reg.first_rd[BUF_ABORT_BIT] && s_reg.dq_s2[BUF_ABORT_BIT] && !s_next.done; // R20
					s_next.ewin  = s_reg.dq_s2[ERASE_WIN_BIT]; // R18
					s_next.alt   = s_reg.first_rd[ALT_TOGGLE_BIT] != s_reg.dq_s2[ALT_TOGGLE_BIT]; // R19
					s_next.recover = s_next.fail || s_next.abort; // R17 R20
					s_next.ce_n  = 1'b1;
					s_next.oe_n  = 1'b1;
					s_next.st    = ST_GAP;
				end else if (s_reg.oe_n) begin
					s_next.cnt = CNT_W'(ACCESS_CYC);
				end
			end
			ST_RST_LOW: begin
				if (s_reg.cnt == CNT_ZERO) begin
					s_next.rst_n = 1'b1;
					s_next.done  = 1'b1;
					s_next.rv    = 1'b1;
					s_next.st    = ST_GAP;
				end
			end
			ST_GAP: begin
				// One idle cycle keeps strobe pulses well apart (R9)
				s_next.ready = !s_reg.recover;
				s_next.st    = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_reg         <= '0;
			s_reg.st      <= ST_IDLE;
			s_reg.ready   <= 1'b1;
			s_reg.ce_n    <= 1'b1;
			s_reg.oe_n    <= 1'b1;
			s_reg.we_n    <= 1'b1;
			s_reg.rst_n   <= 1'b1;
			s_reg.byte_n  <= 1'b1;
			s_reg.dq_oe_n <= 1'b1;
			s_reg.dq_o    <= DATA_ZERO;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cmd_ready        = s_reg.ready;
	assign rsp_valid        = s_reg.rv;
	assign rsp_data         = s_reg.rdata;
	assign rsp_done         = s_reg.done;
	assign rsp_failure      = s_reg.fail;
	assign rsp_abort        = s_reg.abort;
	assign rsp_erase_window = s_reg.ewin;
	assign rsp_alt_toggled  = s_reg.alt;
	assign recover_busy     = s_reg.recover;
	assign flash_addr       = s_reg.addr;
	assign flash_ce_n       = s_reg.ce_n;
	assign flash_oe_n       = s_reg.oe_n;
	assign flash_we_n       = s_reg.we_n;
	assign flash_rst_n      = s_reg.rst_n;
	assign flash_byte_n     = s_reg.byte_n;
	assign flash_dq_o       = s_reg.dq_o;
	assign flash_dq_oe_n    = s_reg.dq_oe_n;
endmodule

// ### test/nfh_host_properties.sv
// Purpose: Bus pin checks on the flash host
// Assumes: Only the ports of nfh_host are seen
// Notes:   Cycle figures follow the hand-over walk
module nfh_host_props
	import nfh_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              srst,
	input wire logic              cmd_valid,
	input wire nfh_op_t           cmd_op,
	input wire logic              cmd_ready,
	input wire logic              rsp_valid,
	input wire logic              recover_busy,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic              flash_ce_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_we_n,
	input wire logic              flash_rst_n,
	input wire logic [DATA_W-1:0] flash_dq_o,
	input wire logic              flash_dq_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire logic take = cmd_valid && cmd_ready && !recover_busy;
	oe_in_write_a: assert property (!flash_we_n |-> flash_oe_n)
		else $error("output enable low in write");
	read_levels_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && flash_rst_n)
		else $error("bad read levels");
	no_clash_a: assert property (!flash_dq_oe_n |-> flash_oe_n)
		else $error("host drives while reading");
	data_latch_a: assert property ($rose(flash_we_n) |-> !flash_dq_oe_n && $stable(flash_dq_o))
		else $error("data not held at strobe rise");
	addr_latch_a: assert property (!flash_we_n |-> !flash_ce_n && $stable(flash_addr))
		else $error("address moved in write");
	write_pulse_a: assert property ($fell(flash_we_n) |-> !flash_we_n[*2] ##1 flash_we_n)
		else $error("write pulse length");
	reset_pulse_a: assert property ($fell(flash_rst_n) |-> !flash_rst_n[*5])
		else $error("reset pulse short");
	read_answer_a: assert property (take && cmd_op == OP_READ |-> ##4 rsp_valid ##1 !rsp_valid)
		else $error("read answer timing");
	standby_a: assert property (flash_ce_n |-> flash_oe_n && flash_we_n)
		else $error("strobe outside select");
	recover_a: assert property ($rose(recover_busy) |-> ##[1:20] ($fell(flash_we_n) && flash_dq_o == CMD_READ_RESET))
		else $error("no read/reset after fault");
endmodule

bind nfh_host nfh_host_props nfh_host_props_i (.*);

// ### test/nfh_flash_model.sv
// Purpose: Behavioural flash device on the host bus
// Assumes: 256 words of array, low address bits only
// Notes:   Undriven data shows inverse of last value
module nfh_flash_model (
	input wire logic [22:0] addr,
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic        rst_n,
	input wire logic        byte_n,
	input wire logic [15:0] din,
	output logic [15:0]     q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [256];
	logic [15:0] last, word;
	logic [22:0] wa;
	int          busy, busy_len;
	logic        fail, abt, fail_on, abt_on, tog, drv, stat;
	logic        wr_on  = 1'b0;
	realtime     t_fall = 0.0;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
		{busy, busy_len, fail, abt, fail_on, abt_on, tog, last, wa} = '0;
	end
	assign stat = busy > 0 || fail || abt;
	assign drv = !ce_n && !oe_n && we_n && rst_n;
	// Status on low byte while busy; single reads only, no page buffer or suspend modelled
	assign word = stat ? {8'h00, ~mem[wa[7:0]][7], tog, fail, 3'h0, abt, 1'b0}
		: mem[addr[7:0]];
	assign q = drv ? {byte_n ? word[15:8] : ~last[15:8], word[7:0]} : ~last;
	always @(drv or word) if (drv) last = word;
	// Later of the two falling strobes latches the address
	always @(negedge we_n or negedge ce_n) if (!ce_n && !we_n && rst_n) begin
		wa = addr;
		wr_on = 1'b1;
		t_fall = $realtime;
	end
	// Counted at the end of a read, so select and enable rising together count once
	always @(negedge drv) if (stat) begin
		tog = ~tog;
		if (busy > 0) busy--;
	end
	always @(posedge we_n or posedge ce_n) if (wr_on) begin
		wr_on = 1'b0;
		// Strobes shorter than 5ns are glitches and start nothing
		if (rst_n && oe_n && $realtime - t_fall >= 5.0) begin
			if (din == 16'h00F0) {fail, abt} = 2'h0;
			else begin
				mem[wa[7:0]] = din;
				busy = busy_len;
				fail = fail_on;
				abt = abt_on;
			end
		end
	end
	always @(negedge rst_n) {busy, fail, abt} = '0;
endmodule

// ### test/tb_nor_flash_bus_and_status.sv
// Purpose: Self-checking bench for the flash host
// Assumes: Word mode but for one byte read; seed fixed
// Notes:   Expected array kept in a shadow copy
module tb_nor_flash_bus_and_status;
	import nfh_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic              ref_clk = 0, srst = 1, cmd_valid = 0, cmd_word_mode = 1;
	nfh_op_t           cmd_op = OP_READ;
	logic [ADDR_W-1:0] cmd_addr = '0, flash_addr, a;
	logic [DATA_W-1:0] cmd_data = '0, rsp_data, flash_dq_o, dev_q, d;
	logic              cmd_ready, rsp_valid, rsp_done, rsp_failure, rsp_abort, rsp_erase_window;
	logic              rsp_alt_toggled, recover_busy, flash_ce_n, flash_oe_n, flash_we_n;
	logic              flash_rst_n, flash_byte_n, flash_dq_oe_n;
	wire logic [15:0]  flash_dq_i = !flash_dq_oe_n ? flash_dq_o : dev_q;
	logic [15:0]       exp_mem [256];
	int                bad_count = 0, cmp_count = 0, cyc = 0, n, k;
	nfh_host nfh_host_i (.*);
	nfh_flash_model nfh_flash_model_i (.addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
		.we_n(flash_we_n), .rst_n(flash_rst_n), .byte_n(flash_byte_n), .din(flash_dq_i), .q(dev_q));
	initial forever #50 ref_clk = ~ref_clk;
	function automatic logic [15:0] exp_word(input logic [22:0] ad);
		return exp_mem[ad[7:0]];
	endfunction
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, tests need a few hundred cycles
	always @(posedge ref_clk) if (++cyc == 20000) begin
		bad_count++;
		tally_and_finish();
	end
	task automatic do_op(input nfh_op_t op, input logic [22:0] ad, input logic [15:0] dd);
		int w;
		w = 0;
		while ((cmd_ready !== 1'b1 || recover_busy !== 1'b0) && w++ < 60) begin
			@(posedge ref_clk);
			#10;
		end
		cmd_valid = 1'b1;
		cmd_op    = op;
		cmd_addr  = ad;
		cmd_data  = dd;
		@(posedge ref_clk);
		#10 cmd_valid = 0;
		w = 0;
		while (op != OP_WRITE && rsp_valid !== 1'b1 && w++ < 60) begin
			@(posedge ref_clk);
			#10;
		end
	endtask
	initial begin
		k = $urandom(53255);
		for (int i = 0; i < 256; i++) exp_mem[i] = {i[7:0], ~i[7:0]};
		repeat (5) @(posedge ref_clk);
		#10 srst = 0;
		chk("ready", cmd_ready, 16'h0001);
		chk("ce_n", flash_ce_n, 16'h0001);
		$display("reset test done");
		repeat (8) begin
			a = ADDR_W'($urandom);
			do_op(OP_READ, a, '0);
			chk("read", rsp_data, exp_word(a));
		end
		$display("read test done");
		cmd_word_mode = 1'b0;
		a = ADDR_W'($urandom);
		do_op(OP_READ, a, '0);
		d = exp_word(a);
		chk("byte read", {8'h00, rsp_data[7:0]}, {8'h00, d[7:0]});
		chk("byte_n", flash_byte_n, 16'h0000);
		cmd_word_mode = 1'b1;
		$display("byte test done");
		// Busy program, then failure, then buffer abort
		for (k = 0; k < 3; k++) begin
			a = ADDR_W'($urandom);
			d = DATA_W'($urandom);
			nfh_flash_model_i.busy_len = k == 0 ? 3 : 0;
			nfh_flash_model_i.fail_on = k == 1;
			nfh_flash_model_i.abt_on = k == 2;
			do_op(OP_WRITE, a, d);
			exp_mem[a[7:0]] = d;
			n = 0;
			do begin
				do_op(OP_POLL, a, '0);
				n++;
			end while (rsp_done !== 1'b1 && rsp_failure !== 1'b1 && rsp_abort !== 1'b1 && n < 10);
			chk("failure", rsp_failure, k == 1);
			chk("abort", rsp_abort, k == 2);
			chk("done", rsp_done, k == 0);
			if (k != 0) begin
				chk("erase window", rsp_erase_window, 16'h0000);
				chk("alt toggle", rsp_alt_toggled, 16'h0000);
			end
			do_op(OP_READ, a, '0);
			chk("after", rsp_data, exp_word(a));
		end
		$display("status test done");
		nfh_flash_model_i.busy_len = 50;
		{nfh_flash_model_i.fail_on, nfh_flash_model_i.abt_on} = 2'h0;
		do_op(OP_WRITE, a, ~d);
		exp_mem[a[7:0]] = ~d;
		do_op(OP_HWRESET, '0, '0);
		do_op(OP_READ, a, '0);
		chk("post reset", rsp_data, exp_word(a));
		$display("hard reset test done");
		tally_and_finish();
	end
endmodule
